// ==== inc/sdc_pkg.sv ====
// SDRAM controller configuration and power control: shared constants and types.
// Assumes a 10 MHz controller clock and an AXI4-Lite register master.
package sdc_pkg;
	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RTIMER = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_SREF = 8'h0C;
	localparam logic [7:0] OFS_LPWR = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic RST_BUS_WIDTH = 1'h1;
	localparam logic [11:0] RST_RTIMER = 12'h800;
	localparam logic [31:0] RST_CFG = 32'h2A99C140;
	localparam int BUS_WIDTH_BIT = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Command modes and timing
	// ----------------------------------------
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_NOP = 3'h1;
	localparam logic [2:0] MODE_PALL = 3'h2;
	localparam logic [2:0] MODE_LMR = 3'h3;
	localparam logic [2:0] MODE_REF = 3'h4;
	localparam logic [3:0] DLY_MIN = 4'h2;
	localparam logic [3:0] CAS_LAT = 4'h2;
	localparam logic [3:0] ONE = 4'h1;
	localparam logic [3:0] COL_BASE = 4'h8;
	localparam logic [3:0] ROW_BASE = 4'hB;
	localparam int PALL_BIT = 10;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
	} sdcCmd_t;
	localparam sdcCmd_t CMD_NOP = 4'h7;
	localparam sdcCmd_t CMD_ACT = 4'h3;
	localparam sdcCmd_t CMD_RD = 4'h5;
	localparam sdcCmd_t CMD_WR = 4'h4;
	localparam sdcCmd_t CMD_PRE = 4'h2;
	localparam sdcCmd_t CMD_REF = 4'h1;
	localparam sdcCmd_t CMD_LMR = 4'h0;
	typedef struct packed {
		logic rsvd;
		logic [3:0] selfRefreshExitDelay;
		logic [3:0] activeToPrechargeDelay;
		logic [3:0] rowToColumnDelay;
		logic [3:0] rowPrechargeDelay;
		logic [3:0] rowCycleDelay;
		logic [3:0] writeRecoveryDelay;
		logic [1:0] cas;
		logic bankCountSelect;
		logic [1:0] rowBitCount;
		logic [1:0] nc;
	} sdcCfg_t;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_WAKE = 8'h02,
		S_ACT = 8'h04,
		S_RW = 8'h08,
		S_PRE = 8'h10,
		S_REF = 8'h20,
		S_SELF = 8'h40,
		S_MODE = 8'h80
	} sdcState_t;
endpackage : sdc_pkg

// ==== verification/sdc_ctrl_tb.sv ====
// Self-checking bench for the SDRAM configuration and power engine.
// Assumes the design package and the SDRAM behavioural model.
`timescale 1ns/100ps
module sdc_ctrl_tb;
	import sdc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] awAddr = 8'h00;
	logic [7:0] arAddr = 8'h00;
	logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
	logic accReq = 1'h0, accWrite = 1'h0;
	logic [31:0] wData = 32'h0;
	logic [3:0] wStrb = 4'hF;
	logic [27:0] accAddr = 28'h0;
	logic awReady, wReady, bValid, arReady, rValid, accAck;
	logic memClockEnable, memClockOut, memHalfWidth;
	logic [1:0] bResp, rResp, memBank, r;
	logic [31:0] rData, d;
	logic [12:0] memAddr, lastAddr;
	sdcCmd_t memCmd, lastCmd;
	logic [15:0] refCount, cmdCount, c0;
	logic [7:0] actGap, tasGap, rpGap, xsrGap;
	sdcCfg_t cfg;
	logic [2:0] mTab [4] = '{MODE_NOP, MODE_PALL, MODE_LMR, MODE_REF};
	sdcCmd_t cTab [4] = '{CMD_NOP, CMD_PRE, CMD_LMR, CMD_REF};
	int num_errors = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	sdc_ctrl i_sdc_ctrl (.clk(clk), .reset_n(reset_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.accReq(accReq), .accWrite(accWrite), .accAddr(accAddr), .accAck(accAck),
		.memCmd(memCmd), .memAddr(memAddr), .memBank(memBank), .memClockEnable(memClockEnable),
		.memClockOut(memClockOut), .memHalfWidth(memHalfWidth));
	sdc_mem_model i_sdc_mem_model (.clk(clk), .reset_n(reset_n), .memCmd(memCmd),
		.memAddr(memAddr), .memClockEnable(memClockEnable), .lastCmd(lastCmd),
		.lastAddr(lastAddr), .refCount(refCount), .cmdCount(cmdCount), .actGap(actGap),
		.tasGap(tasGap), .rpGap(rpGap), .xsrGap(xsrGap));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		awAddr <= a;
		wData <= v;
		awValid <= 1'h1;
		wValid <= 1'h1;
		bReady <= 1'h1;
		do begin
			@(posedge clk);
			if (awReady) awValid <= 1'h0;
			if (wReady) wValid <= 1'h0;
		end while ((awValid && !awReady) || (wValid && !wReady));
		do @(posedge clk); while (bValid !== 1'h1);
		resp = bResp;
		bReady <= 1'h0;
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'h1;
		rReady <= 1'h1;
		do @(posedge clk); while (arReady !== 1'h1);
		arValid <= 1'h0;
		do @(posedge clk); while (rValid !== 1'h1);
		v = rData;
		resp = rResp;
		rReady <= 1'h0;
	endtask : axiRead
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] resp;
		axiWrite(a, v, resp);
		check("bresp", RESP_OKAY, resp);
	endtask : wr
	task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] resp;
		axiRead(a, v, resp);
		check("rresp", RESP_OKAY, resp);
		check(n, exp, v);
	endtask : rdChk
	task automatic access(input logic w, input logic [27:0] a);
		@(posedge clk);
		accReq <= 1'h1;
		accWrite <= w;
		accAddr <= a;
		do @(posedge clk); while (accAck !== 1'h1);
		accReq <= 1'h0;
		repeat (30) @(posedge clk);
	endtask : access
	task end_of_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		rdChk("mode", OFS_MODE, 32'h00000010);
		rdChk("rtimer", OFS_RTIMER, 32'h00000800);
		rdChk("cfg", OFS_CFG, 32'h2A99C140);
		rdChk("lowpower", OFS_LPWR, 32'h0);
		check("halfwidth", 32'h1, memHalfWidth);
		axiRead(8'h30, d, r);
		check("rresp", RESP_SLVERR, r);
		check("rdata", 32'h0, d);
		axiWrite(8'h34, 32'hFFFFFFFF, r);
		check("bresp", RESP_SLVERR, r);
		repeat (2100) @(posedge clk);
		check("refcount", 32'h0, refCount);
		for (int i = 0; i < 4; i++) begin
			c0 = cmdCount;
			wr(OFS_MODE, 32'h00000010 | {29'h0, mTab[i]});
			access(1'h0, 28'h0000032);
			check("cmdcount", {31'h0, i != 0}, cmdCount - c0);
			if (i != 0) check("cmd", cTab[i], lastCmd);
			if (i == 1) check("pall", 32'h1, lastAddr[PALL_BIT]);
			if (i == 2) check("lmr", 32'h032, lastAddr);
		end
		wr(OFS_MODE, 32'h0);
		@(negedge clk);
		check("halfwidth", 32'h0, memHalfWidth);
		cfg = '{1'h0, 4'h6, 4'h9, 4'h5, 4'h4, 4'h3, 4'h3, 2'h2, 1'h1, 2'h1, 2'h2};
		wr(OFS_CFG, cfg);
		rdChk("cfg", OFS_CFG, cfg);
		access(1'h0, 28'h3001000);
		check("bank", 32'h3, memBank);
		access(1'h1, 28'h0002000);
		check("actgap", 32'h5, actGap);
		check("tasmin", 32'h1, tasGap >= 8'h09);
		check("rpmin", 32'h1, rpGap >= 8'h04);
		check("cmd", CMD_PRE, lastCmd);
		wr(OFS_CFG, sdcCfg_t'{1'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0, 4'h1, 2'h2, 1'h1, 2'h1, 2'h0});
		access(1'h1, 28'h0003000);
		check("actgap", 32'h2, actGap);
		check("recovery", 32'h4, tasGap);
		check("rpmin", 32'h1, rpGap >= 8'h02);
		wr(OFS_CFG, cfg);
		wr(OFS_SREF, 32'h1);
		repeat (10) @(posedge clk);
		check("cke", 32'h0, memClockEnable);
		check("cmd", CMD_REF, lastCmd);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			check("memclock", 32'h0, memClockOut);
		end
		rdChk("sref", OFS_SREF, 32'h0);
		access(1'h0, 28'h0004000);
		check("cke", 32'h1, memClockEnable);
		check("xsr", 32'h1, xsrGap >= 8'h06);
		check("actgap", 32'h5, actGap);
		wr(OFS_LPWR, 32'h1);
		access(1'h1, 28'h0005000);
		check("cke", 32'h0, memClockEnable);
		c0 = cmdCount;
		access(1'h0, 28'h0006000);
		check("cmdcount", 32'h3, cmdCount - c0);
		rdChk("lowpower", OFS_LPWR, 32'h1);
		wr(OFS_LPWR, 32'h0);
		access(1'h0, 28'h0007000);
		check("cke", 32'h1, memClockEnable);
		wr(OFS_RTIMER, 32'h20);
		c0 = refCount;
		repeat (330) @(posedge clk);
		check("refrate", 32'h1, (refCount - c0) inside {[16'h9 : 16'hB]});
		wr(OFS_RTIMER, 32'h0);
		repeat (20) @(posedge clk);
		c0 = refCount;
		repeat (100) @(posedge clk);
		check("refstop", 32'h0, refCount - c0);
		wr(OFS_RTIMER, 32'h2);
		repeat (60) @(posedge clk);
		wr(OFS_RTIMER, 32'h0);
		repeat (20) @(posedge clk);
		rdChk("referr", OFS_STAT, 32'h1);
		rdChk("referr", OFS_STAT, 32'h0);
		end_of_test;
	end
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test;
	end
endmodule : sdc_ctrl_tb

// ==== verification/sdc_mem_model.sv ====
// Behavioural SDRAM device: watches the command bus and keeps timing figures.
// Assumes commands are sampled on the controller clock's rising edge.
`timescale 1ns/100ps
module sdc_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Command bus
	input wire sdc_pkg::sdcCmd_t memCmd,
	input wire logic [12:0] memAddr,
	input wire logic memClockEnable,
	// Observations
	output sdc_pkg::sdcCmd_t lastCmd,
	output logic [12:0] lastAddr,
	output logic [15:0] refCount,
	output logic [15:0] cmdCount,
	output logic [7:0] actGap,
	output logic [7:0] tasGap,
	output logic [7:0] rpGap,
	output logic [7:0] xsrGap
);
	import sdc_pkg::*;
	// ----------------------------------------
	// Command decoder and gap counters
	// ----------------------------------------
	logic [7:0] sinceAct;
	logic [7:0] sincePre;
	logic [7:0] sinceCke;
	logic ckePrev;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lastCmd <= CMD_NOP;
			lastAddr <= 13'h0000;
			refCount <= 16'h0000;
			cmdCount <= 16'h0000;
			{actGap, tasGap, rpGap, xsrGap} <= 32'h0;
			{sinceAct, sincePre, sinceCke} <= 24'h0;
			ckePrev <= 1'h1;
		end else begin
			ckePrev <= memClockEnable;
			sinceAct <= (sinceAct == 8'hFF) ? sinceAct : sinceAct + 8'h01;
			sincePre <= (sincePre == 8'hFF) ? sincePre : sincePre + 8'h01;
			sinceCke <= (sinceCke == 8'hFF) ? sinceCke : sinceCke + 8'h01;
			if (memClockEnable && !ckePrev) begin
				sinceCke <= 8'h01;
			end
			if (memCmd != CMD_NOP) begin
				lastCmd <= memCmd;
				lastAddr <= memAddr;
				cmdCount <= cmdCount + 16'h0001;
			end
			case (memCmd)
				CMD_ACT: begin
					sinceAct <= 8'h01;
					rpGap <= sincePre;
					xsrGap <= sinceCke;
				end
				CMD_RD, CMD_WR: begin
					actGap <= sinceAct;
				end
				CMD_PRE: begin
					tasGap <= sinceAct;
					sincePre <= 8'h01;
				end
				CMD_REF: begin
					refCount <= refCount + 16'h0001;
				end
				default: begin
				end
			endcase
		end
	end
endmodule : sdc_mem_model

// ==== verilog/sdc_ctrl.sv ====
// SDRAM controller command, refresh and power-state engine with its registers.
// Assumes an AXI4-Lite master on clk and an access requester on clk that holds
// accReq until accAck and drops it the cycle after.
`timescale 1ns/100ps
module sdc_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Access requests
	input wire logic accReq,
	input wire logic accWrite,
	input wire logic [27:0] accAddr,
	output logic accAck,
	// SDRAM side
	output sdc_pkg::sdcCmd_t memCmd,
	output logic [12:0] memAddr,
	output logic [1:0] memBank,
	output logic memClockEnable,
	output logic memClockOut,
	output logic memHalfWidth
);
	import sdc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] eff(input logic [3:0] v);
		eff = (v <= DLY_MIN) ? DLY_MIN : v;
	endfunction : eff

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_MODE) || (a == OFS_RTIMER) || (a == OFS_CFG) ||
			(a == OFS_SREF) || (a == OFS_LPWR) || (a == OFS_STAT);
	endfunction : mapped

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[i*8 +: 8] = n[i*8 +: 8];
			end
		end
	endfunction : merge

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [2:0] cmdMode_q;
	logic busWidthSelect_q;
	logic [11:0] rtCount_q;
	logic rtWritten_q;
	sdcCfg_t cfg_q;
	logic lowPowerRequestBit_q;
	logic srReq_q;
	logic refreshErrorFlag_q;
	logic refPend_q;
	logic [11:0] rtTimer_q;
	logic refTick;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrDo;
	logic rdDo;
	logic [31:0] rdMux;
	logic [31:0] curWord;
	logic [31:0] newWord;
	sdcState_t state_q;
	logic [3:0] dly_q;
	logic refTake;
	logic srTake;
	logic modeIssue;
	logic [3:0] sinceAct_q;

	assign wrDo = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign rdDo = s_axi_arvalid && s_axi_arready;

	// ----------------------------------------
	// AXI write channels
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0;
			wStrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrDo) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read mux and read channel
	// ----------------------------------------
	always_comb begin
		curWord = 32'h0;
		case (awAddr_q)
			OFS_MODE: curWord = {27'h0, busWidthSelect_q, 1'b0, cmdMode_q};
			OFS_RTIMER: curWord = {20'h0, rtCount_q};
			OFS_CFG: curWord = cfg_q;
			OFS_LPWR: curWord = {31'h0, lowPowerRequestBit_q};
			default: curWord = 32'h0;
		endcase
		newWord = merge(curWord, wData_q, wStrb_q);
		rdMux = 32'h0;
		case (s_axi_araddr)
			OFS_MODE: rdMux = {27'h0, busWidthSelect_q, 1'b0, cmdMode_q};
			OFS_RTIMER: rdMux = {20'h0, rtCount_q};
			OFS_CFG: rdMux = cfg_q;
			OFS_LPWR: rdMux = {31'h0, lowPowerRequestBit_q};
			OFS_STAT: rdMux = {31'h0, refreshErrorFlag_q};
			default: rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rdDo) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdMode_q <= RST_MODE;
			busWidthSelect_q <= RST_BUS_WIDTH;
			rtCount_q <= RST_RTIMER;
			rtWritten_q <= 1'b0;
			cfg_q <= RST_CFG;
			lowPowerRequestBit_q <= 1'b0;
		end else if (wrDo) begin
			case (awAddr_q)
				OFS_MODE: begin
					cmdMode_q <= newWord[2:0];
					busWidthSelect_q <= newWord[BUS_WIDTH_BIT];
				end
				OFS_RTIMER: begin
					rtCount_q <= newWord[11:0];
					rtWritten_q <= rtWritten_q | (|wStrb_q[1:0]);
				end
				OFS_CFG: cfg_q <= newWord;
				OFS_LPWR: lowPowerRequestBit_q <= newWord[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			memHalfWidth <= RST_BUS_WIDTH;
		end else begin
			memHalfWidth <= busWidthSelect_q;
		end
	end

	// ----------------------------------------
	// Refresh timer and error flag
	// ----------------------------------------
	assign refTick = rtWritten_q && (rtCount_q != 12'h0) && (rtTimer_q == 12'h0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rtTimer_q <= 12'h0;
		end else if (wrDo && awAddr_q == OFS_RTIMER) begin
			rtTimer_q <= newWord[11:0] - 12'h1;
		end else if (!rtWritten_q || refTick) begin
			rtTimer_q <= rtCount_q - 12'h1;
		end else begin
			rtTimer_q <= rtTimer_q - 12'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			refPend_q <= 1'b0;
			refreshErrorFlag_q <= 1'b0;
		end else begin
			if (refTick) begin
				refPend_q <= 1'b1;
			end else if (refTake) begin
				refPend_q <= 1'b0;
			end
			if (refTick && refPend_q && state_q != S_SELF) begin
				refreshErrorFlag_q <= 1'b1;
			end else if (rdDo && s_axi_araddr == OFS_STAT) begin
				refreshErrorFlag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			srReq_q <= 1'b0;
		end else if (wrDo && awAddr_q == OFS_SREF && wStrb_q[0] && wData_q[0]) begin
			srReq_q <= 1'b1;
		end else if (srTake) begin
			srReq_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Address split
	// ----------------------------------------
	logic [27:0] wordAddr;
	logic [3:0] colBits;
	logic [3:0] rowBits;
	logic [27:0] colPart;
	logic [27:0] rowPart;
	logic [27:0] bankPart;

	always_comb begin
		wordAddr = busWidthSelect_q ? (accAddr >> 1) : (accAddr >> 2);
		colBits = COL_BASE + {2'h0, cfg_q.nc};
		rowBits = ROW_BASE + ((cfg_q.rowBitCount == 2'h3) ? 4'h2 : {2'h0, cfg_q.rowBitCount});
		colPart = wordAddr & ((28'h1 << colBits) - 28'h1);
		rowPart = (wordAddr >> colBits) & ((28'h1 << rowBits) - 28'h1);
		bankPart = (wordAddr >> ({1'b0, colBits} + {1'b0, rowBits}))
			& (cfg_q.bankCountSelect ? 28'h3 : 28'h1);
	end

	// ----------------------------------------
	// Command engine
	// ----------------------------------------
	logic [3:0] rcdEff;
	logic [3:0] rasEff;
	logic [3:0] colWait;

	assign rcdEff = eff(cfg_q.rowToColumnDelay);
	assign rasEff = eff(cfg_q.activeToPrechargeDelay);
	assign colWait = accWrite ? eff(cfg_q.writeRecoveryDelay) : CAS_LAT;
	assign refTake = (state_q == S_IDLE) && refPend_q && memClockEnable;
	assign srTake = (state_q == S_IDLE) && !refPend_q && srReq_q && memClockEnable;
	assign modeIssue = (state_q == S_IDLE) && !refPend_q && !srReq_q && memClockEnable
		&& accReq && (cmdMode_q != MODE_NORMAL);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= S_IDLE;
			dly_q <= 4'h0;
			memCmd <= CMD_NOP;
			memAddr <= 13'h0;
			memBank <= 2'h0;
			memClockEnable <= 1'b1;
			accAck <= 1'b0;
		end else begin
			memCmd <= CMD_NOP;
			accAck <= 1'b0;
			if (dly_q != 4'h0) begin
				dly_q <= dly_q - ONE;
			end
			case (state_q)
				S_IDLE: begin
					if (!memClockEnable) begin
						if (accReq || refPend_q || !lowPowerRequestBit_q) begin
							memClockEnable <= 1'b1;
							dly_q <= 4'h0;
							state_q <= S_WAKE;
						end
					end else if (refTake) begin
						memCmd <= CMD_REF;
						dly_q <= eff(cfg_q.rowCycleDelay) - ONE;
						state_q <= S_REF;
					end else if (srTake) begin
						memCmd <= CMD_REF;
						memClockEnable <= 1'b0;
						state_q <= S_SELF;
					end else if (modeIssue) begin
						accAck <= 1'b1;
						dly_q <= DLY_MIN - ONE;
						state_q <= S_MODE;
						case (cmdMode_q)
							MODE_PALL: begin
								memCmd <= CMD_PRE;
								memAddr <= 13'h0;
								memAddr[PALL_BIT] <= 1'b1;
								dly_q <= eff(cfg_q.rowPrechargeDelay) - ONE;
							end
							MODE_LMR: begin
								memCmd <= CMD_LMR;
								memAddr <= accAddr[12:0];
								memBank <= accAddr[14:13];
							end
							MODE_REF: begin
								memCmd <= CMD_REF;
								dly_q <= eff(cfg_q.rowCycleDelay) - ONE;
							end
							default: memCmd <= CMD_NOP;
						endcase
					end else if (accReq) begin
						memCmd <= CMD_ACT;
						memAddr <= rowPart[12:0];
						memBank <= bankPart[1:0];
						dly_q <= rcdEff - ONE;
						state_q <= S_ACT;
					end
				end
				S_SELF: begin
					if (accReq) begin
						memClockEnable <= 1'b1;
						dly_q <= (cfg_q.selfRefreshExitDelay == 4'h0) ? 4'h0
							: cfg_q.selfRefreshExitDelay - ONE;
						state_q <= S_WAKE;
					end
				end
				S_ACT: begin
					if (dly_q == 4'h0) begin
						memCmd <= accWrite ? CMD_WR : CMD_RD;
						memAddr <= {1'b0, colPart[10], 1'b0, colPart[9:0]};
						accAck <= 1'b1;
						state_q <= S_RW;
						dly_q <= colWait - ONE;
						if ({1'b0, rasEff} > {1'b0, rcdEff} + {1'b0, colWait}) begin
							dly_q <= rasEff - rcdEff - ONE;
						end
					end
				end
				S_RW: begin
					if (dly_q == 4'h0) begin
						memCmd <= CMD_PRE;
						memAddr[PALL_BIT] <= 1'b1;
						dly_q <= eff(cfg_q.rowPrechargeDelay) - ONE;
						state_q <= S_PRE;
					end
				end
				S_PRE: begin
					if (dly_q == 4'h0) begin
						// enter low power, only when set
						memClockEnable <= !lowPowerRequestBit_q;
						state_q <= S_IDLE;
					end
				end
				S_WAKE, S_REF, S_MODE: begin
					if (dly_q == 4'h0) begin
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			memClockOut <= 1'b0;
		end else if (state_q == S_SELF) begin
			memClockOut <= 1'b0;
		end else begin
			memClockOut <= !memClockOut;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sinceAct_q <= 4'hF;
		end else if (memCmd == CMD_ACT) begin
			sinceAct_q <= ONE;
		end else if (sinceAct_q != 4'hF) begin
			sinceAct_q <= sinceAct_q + ONE;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_noRefUnarmed;
		@(posedge clk) disable iff (!reset_n) !rtWritten_q |-> !refPend_q;
	endproperty
	a_noRefUnarmed: assert property (p_noRefUnarmed) else $error("refresh before arm");

	property p_tickPend;
		@(posedge clk) disable iff (!reset_n) refTick |=> refPend_q || $past(refTake);
	endproperty
	a_tickPend: assert property (p_tickPend) else $error("refresh tick lost");

	property p_refErr;
		@(posedge clk) disable iff (!reset_n)
			refTick && refPend_q && state_q != S_SELF |=> refreshErrorFlag_q;
	endproperty
	a_refErr: assert property (p_refErr) else $error("refresh error not flagged");

	property p_lowPowerOnly;
		@(posedge clk) disable iff (!reset_n)
			$fell(memClockEnable) |-> memCmd == CMD_REF || $past(lowPowerRequestBit_q);
	endproperty
	a_lowPowerOnly: assert property (p_lowPowerOnly) else $error("stray clock enable drop");

	property p_selfEnter;
		@(posedge clk) disable iff (!reset_n)
			srTake |=> !memClockEnable && memCmd == CMD_REF ##1 !memClockOut;
	endproperty
	a_selfEnter: assert property (p_selfEnter) else $error("self-refresh entry wrong");

	property p_nopMode;
		@(posedge clk) disable iff (!reset_n)
			modeIssue && cmdMode_q == MODE_NOP |=> memCmd == CMD_NOP && accAck;
	endproperty
	a_nopMode: assert property (p_nopMode) else $error("nop mode wrong");

	property p_pallMode;
		@(posedge clk) disable iff (!reset_n)
			modeIssue && cmdMode_q == MODE_PALL |=> memCmd == CMD_PRE && memAddr[PALL_BIT];
	endproperty
	a_pallMode: assert property (p_pallMode) else $error("precharge-all mode wrong");

	property p_actToCol;
		@(posedge clk) disable iff (!reset_n)
			memCmd == CMD_RD || memCmd == CMD_WR |-> sinceAct_q >= rcdEff;
	endproperty
	a_actToCol: assert property (p_actToCol) else $error("column too soon");
endmodule : sdc_ctrl
